// ### design/mrps_pkg.sv
// shared constants and types of the multi-rail power sequencer
package mrps_pkg;
    // =========================================================
    // sizes
    localparam int N_RAILS = 12;
    localparam int DLY_W = 12;
    localparam int GPI_N = 8;
    localparam int GPI_SEL_W = 3;
    localparam int VMON_W = 12;
    // =========================================================
    // timing
    localparam int TON_MAX_DLY_MS = 3276;
    localparam int TOFF_MAX_DLY_MS = 3276;
    localparam int CLK_FREQ_KHZ = 40000;
    localparam int TICK_MS = 1;
    localparam int CLK_PER_MS = CLK_FREQ_KHZ * TICK_MS;
    localparam logic [DLY_W-1:0] TON_CAP = DLY_W'(TON_MAX_DLY_MS);
    localparam logic [DLY_W-1:0] TOFF_CAP = DLY_W'(TOFF_MAX_DLY_MS);
    // =========================================================
    // types and reset values
    typedef enum logic [3:0] {
        RS_OFF = 4'h1,
        RS_WAIT_ON = 4'h2,
        RS_ON = 4'h4,
        RS_WAIT_OFF = 4'h8
    } mrps_state_t;
    typedef logic [N_RAILS-1:0] mrps_rvec_t;
    typedef logic [N_RAILS-1:0][DLY_W-1:0] mrps_rdly_t;
    typedef logic [N_RAILS-1:0][N_RAILS-1:0] mrps_rmask_t;
    typedef logic [N_RAILS-1:0][GPI_SEL_W-1:0] mrps_rsel_t;
    typedef logic [N_RAILS-1:0][VMON_W-1:0] mrps_rvolt_t;
    localparam mrps_state_t STATE_RST = RS_OFF;
    localparam mrps_rvec_t RVEC_RST = 12'h000;
    localparam logic [DLY_W-1:0] DLY_RST = 12'h000;
endpackage : mrps_pkg

// ### design/mrps_tmr_if.sv
// timebase and per-rail delay timer signals
`timescale 1ns/100ps
`default_nettype none
interface mrps_tmr_if;
    import mrps_pkg::*;
    logic tick;
    mrps_rvec_t load;
    mrps_rdly_t val;
    mrps_rvec_t exp;
    modport tb (output tick);
    modport ct (input tick, input load, input val, output exp);
    modport seq (input tick, output load, output val, input exp);
endinterface : mrps_tmr_if
`default_nettype wire

// ### design/mrps_ms_tick.sv
// millisecond tick divider
`timescale 1ns/100ps
`default_nettype none
module mrps_ms_tick #(
    parameter int CLK_PER_MS = mrps_pkg::CLK_PER_MS
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // tick out
    mrps_tmr_if.tb tb
);
    import mrps_pkg::*;
    localparam int CW = $clog2(CLK_PER_MS + 1);
    localparam logic [CW-1:0] LAST = CW'(CLK_PER_MS - 1);
    logic [CW-1:0] cnt_q, cnt_d;
    logic tick_q, tick_d;
    // =========================================================
    // divider: one-cycle tick every CLK_PER_MS cycles
    always_comb begin
        tick_d = (cnt_q == LAST);
        cnt_d = tick_d ? '0 : cnt_q + 1'b1;
    end
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end
    assign tb.tick = tick_q;
endmodule : mrps_ms_tick
`default_nettype wire

// ### design/mrps_rail_timer.sv
// one down-counting delay timer per rail on the ms tick
`timescale 1ns/100ps
`default_nettype none
module mrps_rail_timer (
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // load and expiry
    mrps_tmr_if.ct ct
);
    import mrps_pkg::*;
    mrps_rdly_t cnt_q, cnt_d;
    mrps_rvec_t arm_q, arm_d;
    mrps_rvec_t exp_c;
    // =========================================================
    // counters: load wins over expiry so a restart is never lost
    always_comb begin
        cnt_d = cnt_q;
        arm_d = arm_q;
        exp_c = '0;
        for (int r = 0; r < N_RAILS; r++) begin
            exp_c[r] = arm_q[r] && (cnt_q[r] == DLY_RST);
            if (ct.load[r]) begin
                cnt_d[r] = ct.val[r];
                arm_d[r] = 1'b1;
            end else if (exp_c[r]) begin
                arm_d[r] = 1'b0;
            end else if (arm_q[r] && ct.tick) begin
                cnt_d[r] = cnt_q[r] - 1'b1;
            end
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            cnt_q <= '0;
            arm_q <= RVEC_RST;
        end else begin
            cnt_q <= cnt_d;
            arm_q <= arm_d;
        end
    end
    assign ct.exp = exp_c; // same-cycle, stays one cycle only
endmodule : mrps_rail_timer
`default_nettype wire

// ### design/mrps_top.sv
// multi-rail power sequencer: triggers, rail state machines, faults
`timescale 1ns/100ps
`default_nettype none
module mrps_top #(
    parameter int CLK_PER_MS = mrps_pkg::CLK_PER_MS
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    // start mode, commands and pins
    input wire logic auto_start_in,
    input wire logic pin_mode_in,
    input wire logic op_on_cmd_in,
    input wire logic op_off_cmd_in,
    input wire logic sequence_control_pin_in,
    input wire logic [mrps_pkg::GPI_N-1:0] general_input_pin_in,
    // turn-on configuration
    input wire mrps_pkg::mrps_rvec_t on_by_op_in,
    input wire mrps_pkg::mrps_rvec_t on_by_pin_in,
    input wire mrps_pkg::mrps_rvec_t on_by_parent_in,
    input wire mrps_pkg::mrps_rvec_t on_by_gpi_in,
    input wire mrps_pkg::mrps_rmask_t on_parent_mask_in,
    input wire mrps_pkg::mrps_rsel_t on_gpi_sel_in,
    input wire mrps_pkg::mrps_rvec_t on_gpi_level_in,
    input wire mrps_pkg::mrps_rvec_t on_monitor_only_in,
    // turn-off configuration
    input wire mrps_pkg::mrps_rvec_t off_by_op_in,
    input wire mrps_pkg::mrps_rvec_t off_by_pin_in,
    input wire mrps_pkg::mrps_rvec_t off_by_gpi_in,
    input wire mrps_pkg::mrps_rsel_t off_gpi_sel_in,
    input wire mrps_pkg::mrps_rvec_t off_gpi_level_in,
    input wire mrps_pkg::mrps_rvec_t off_monitor_only_in,
    input wire mrps_pkg::mrps_rvec_t off_immediate_in,
    input wire mrps_pkg::mrps_rmask_t fault_follow_mask_in,
    // delays in ms
    input wire mrps_pkg::mrps_rdly_t ton_delay_in,
    input wire mrps_pkg::mrps_rdly_t toff_delay_in,
    input wire mrps_pkg::mrps_rdly_t ton_max_in,
    // monitoring
    input wire mrps_pkg::mrps_rvolt_t rail_volt_in,
    input wire mrps_pkg::mrps_rvolt_t pg_on_thr_in,
    input wire mrps_pkg::mrps_rvolt_t pg_off_thr_in,
    input wire mrps_pkg::mrps_rvec_t rail_fault_in,
    input wire mrps_pkg::mrps_rvec_t fault_clear_in,
    // rail outputs
    output mrps_pkg::mrps_rvec_t rail_enable_out,
    output mrps_pkg::mrps_rvec_t rail_pgood_out,
    output mrps_pkg::mrps_rvec_t ton_max_fault_out,
    output mrps_pkg::mrps_rvec_t rail_faulted_out,
    output logic cascade_shutdown_out
);
    import mrps_pkg::*;

    // =========================================================
    // helpers
    function automatic logic [DLY_W-1:0] cap_dly(input logic [DLY_W-1:0] v,
                                                 input logic [DLY_W-1:0] cap);
        cap_dly = (v > cap) ? cap : v;
    endfunction : cap_dly

    function automatic logic gpi_hit(input logic [GPI_N-1:0] pins,
                                     input logic [GPI_SEL_W-1:0] sel,
                                     input logic lvl);
        gpi_hit = (pins[sel] == lvl);
    endfunction : gpi_hit

    // =========================================================
    // timebase and per-rail timers
    mrps_tmr_if tif ();
    mrps_ms_tick #(.CLK_PER_MS(CLK_PER_MS)) u_tick (
        .clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .tb(tif.tb)
    );
    mrps_rail_timer u_tmr (
        .clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .ct(tif.ct)
    );

    // =========================================================
    // pin synchronisers
    logic pin_s1_q, pin_s2_q;
    logic [GPI_N-1:0] gpi_s1_q, gpi_s2_q;
    // pins are asynchronous; only the second stage is read
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            gpi_s1_q <= '0;
            gpi_s2_q <= '0;
        end else begin
            pin_s1_q <= sequence_control_pin_in;
            pin_s2_q <= pin_s1_q;
            gpi_s1_q <= general_input_pin_in;
            gpi_s2_q <= gpi_s1_q;
        end
    end

    // =========================================================
    // state
    logic op_on_q, op_on_d;
    mrps_state_t st_q [N_RAILS];
    mrps_state_t st_d [N_RAILS];
    mrps_rvec_t en_q, en_d, pg_q, pg_d, tmf_q, tmf_d, flt_q, flt_d;
    logic casc_q, casc_d;
    logic op_req;
    mrps_rvec_t on_ok, off_req, tmax_hit, ld_c;
    mrps_rdly_t ldv_c;

    // =========================================================
    // on/off command latch; on wins if both arrive together
    always_comb begin
        op_on_d = op_on_q;
        if (auto_start_in || pin_mode_in) begin
            op_on_d = 1'b0;
        end else if (op_on_cmd_in) begin
            op_on_d = 1'b1;
        end else if (op_off_cmd_in) begin
            op_on_d = 1'b0;
        end
    end

    // =========================================================
    // trigger evaluation per rail; selected on triggers are all required, any fault or unmasked off trigger is enough (auto start waives op and pin in both)
    always_comb begin
        op_req = pin_mode_in ? pin_s2_q : op_on_q;
        for (int r = 0; r < N_RAILS; r++) begin
            on_ok[r] = (!on_by_op_in[r] || auto_start_in || op_req)
                && (!on_by_pin_in[r] || auto_start_in || pin_s2_q)
                && (!on_by_parent_in[r] || &(pg_q | ~on_parent_mask_in[r]))
                && (!on_by_gpi_in[r] ||
                    gpi_hit(gpi_s2_q, on_gpi_sel_in[r], on_gpi_level_in[r]))
                && (auto_start_in || on_by_op_in[r] || on_by_pin_in[r] ||
                    on_by_parent_in[r] || on_by_gpi_in[r]);
            tmax_hit[r] = (st_q[r] == RS_ON) && (ton_max_in[r] != DLY_RST)
                && !pg_q[r] && tif.exp[r];
            off_req[r] = (!off_monitor_only_in[r] && (
                    (off_by_op_in[r] && !auto_start_in && !op_req) ||
                    (off_by_pin_in[r] && !auto_start_in && !pin_s2_q) ||
                    (off_by_gpi_in[r] &&
                     gpi_hit(gpi_s2_q, off_gpi_sel_in[r], off_gpi_level_in[r]))))
                || flt_q[r] || tmax_hit[r]
                || |(flt_q & fault_follow_mask_in[r]);
        end
    end

    // =========================================================
    // rail sequencing state machines and timer loads
    always_comb begin
        ld_c = '0;
        ldv_c = '0;
        for (int r = 0; r < N_RAILS; r++) begin
            st_d[r] = st_q[r];
            unique case (st_q[r])
                RS_OFF: begin
                    if (on_ok[r] && !on_monitor_only_in[r] && !off_req[r]) begin
                        st_d[r] = RS_WAIT_ON;
                        ld_c[r] = 1'b1;
                        ldv_c[r] = cap_dly(ton_delay_in[r], TON_CAP);
                    end
                end
                RS_WAIT_ON: begin
                    // trigger lost or off request aborts the pending start
                    if (off_req[r] || !on_ok[r]) begin
                        st_d[r] = RS_OFF;
                    end else if (tif.exp[r]) begin
                        st_d[r] = RS_ON;
                        ld_c[r] = (ton_max_in[r] != DLY_RST);
                        ldv_c[r] = ton_max_in[r];
                    end
                end
                RS_ON: begin
                    if (off_req[r]) begin
                        if (off_immediate_in[r]) begin
                            st_d[r] = RS_OFF;
                        end else begin
                            st_d[r] = RS_WAIT_OFF;
                            ld_c[r] = 1'b1;
                            ldv_c[r] = cap_dly(toff_delay_in[r], TOFF_CAP);
                        end
                    end
                end
                RS_WAIT_OFF: begin
                    // an off in progress always completes
                    if (tif.exp[r]) begin
                        st_d[r] = RS_OFF;
                    end
                end
                default: st_d[r] = STATE_RST;
            endcase
        end
    end
    assign tif.load = ld_c;
    assign tif.val = ldv_c;

    // =========================================================
    // outputs, power-good hysteresis and sticky faults (set wins)
    always_comb begin
        for (int r = 0; r < N_RAILS; r++) begin
            en_d[r] = (st_d[r] == RS_ON) || (st_d[r] == RS_WAIT_OFF);
            pg_d[r] = pg_q[r] ? (rail_volt_in[r] >= pg_off_thr_in[r])
                              : (rail_volt_in[r] >= pg_on_thr_in[r]);
        end
        tmf_d = (tmf_q & ~fault_clear_in) | tmax_hit;
        flt_d = (flt_q & ~fault_clear_in) | rail_fault_in | tmax_hit;
        casc_d = |flt_d; // shuts down cascaded devices
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            op_on_q <= 1'b0;
            for (int r = 0; r < N_RAILS; r++) begin
                st_q[r] <= STATE_RST;
            end
            en_q <= RVEC_RST;
            pg_q <= RVEC_RST;
            tmf_q <= RVEC_RST;
            flt_q <= RVEC_RST;
            casc_q <= 1'b0;
        end else begin
            op_on_q <= op_on_d;
            st_q <= st_d;
            en_q <= en_d;
            pg_q <= pg_d;
            tmf_q <= tmf_d;
            flt_q <= flt_d;
            casc_q <= casc_d;
        end
    end

    assign rail_enable_out = en_q;
    assign rail_pgood_out = pg_q;
    assign ton_max_fault_out = tmf_q;
    assign rail_faulted_out = flt_q;
    assign cascade_shutdown_out = casc_q;

    // =========================================================
    // checks
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);

    for (genvar g = 0; g < N_RAILS; g++) begin : g_chk
        a_on_after_delay: assert property (
            (st_q[g] == RS_WAIT_ON && tif.exp[g] && on_ok[g] && !off_req[g])
            |=> (st_q[g] == RS_ON && rail_enable_out[g]))
            else $error("rail not enabled after on delay");
        a_mon_only_on: assert property (
            (st_q[g] == RS_OFF && on_monitor_only_in[g]) |=> !rail_enable_out[g])
            else $error("monitor-only rail enabled");
        a_pg_rise: assert property (
            (!pg_q[g] && rail_volt_in[g] >= pg_on_thr_in[g]) |=> rail_pgood_out[g])
            else $error("power good not set at on level");
        a_pg_hold: assert property (
            (pg_q[g] && rail_volt_in[g] >= pg_off_thr_in[g]) |=> rail_pgood_out[g])
            else $error("power good dropped above off level");
        a_tmax_flag: assert property (
            (st_q[g] == RS_ON && ton_max_in[g] != DLY_RST && tif.exp[g] && !pg_q[g])
            |=> (ton_max_fault_out[g] && st_q[g] != RS_ON))
            else $error("max turn-on expiry not flagged");
        a_tmax_none: assert property (
            (st_q[g] == RS_ON && ton_max_in[g] == DLY_RST && !tmf_q[g])
            |=> !ton_max_fault_out[g])
            else $error("max turn-on fault with no limit");
        a_imm_off: assert property (
            (st_q[g] == RS_ON && off_req[g] && off_immediate_in[g])
            |=> (st_q[g] == RS_OFF && !rail_enable_out[g]))
            else $error("immediate off not taken");
        a_seq_off: assert property (
            (st_q[g] == RS_ON && off_req[g] && !off_immediate_in[g]
             && toff_delay_in[g] != DLY_RST) // a zero delay may end in the next cycle
            |=> (st_q[g] == RS_WAIT_OFF && rail_enable_out[g]) ##1 !tif.exp[g])
            else $error("sequenced off not started");
        a_off_done: assert property (
            (st_q[g] == RS_WAIT_OFF && tif.exp[g]) |=> !rail_enable_out[g])
            else $error("rail still enabled after off delay");
        a_follow_off: assert property (
            (st_q[g] == RS_ON && |(flt_q & fault_follow_mask_in[g]))
            |=> st_q[g] != RS_ON)
            else $error("follower ignored leader fault");
    end

    c_rail_on: cover property (st_q[0] == RS_WAIT_ON ##1 st_q[0] == RS_ON);
    c_tmax_fault: cover property ($rose(ton_max_fault_out[0]));
    c_seq_off: cover property (st_q[0] == RS_WAIT_OFF ##1 st_q[0] == RS_OFF);
    c_cascade: cover property ($rose(cascade_shutdown_out));
endmodule : mrps_top
`default_nettype wire

// ### sim/mrps_supply_model.sv
// behavioural supplies that answer the rail enables with a measured code
`timescale 1ns/100ps
`default_nettype none
module mrps_supply_model #(
    parameter int RAMP = 4
) (
    // clock
    input wire logic clk_in,
    // enables and injected misbehaviour
    input wire mrps_pkg::mrps_rvec_t en_in,
    input wire mrps_pkg::mrps_rvec_t stall_in,
    input wire mrps_pkg::mrps_rvec_t droop_in,
    // measured codes
    output var mrps_pkg::mrps_rvolt_t volt_out
);
    import mrps_pkg::*;
    int cnt [N_RAILS];
    // =========================================================
    // ramp
    // output rises only after a ramp time; discharges once disabled
    always @(posedge clk_in) begin
        for (int r = 0; r < N_RAILS; r++) begin
            cnt[r] <= en_in[r] ? ((cnt[r] < RAMP) ? cnt[r] + 1 : cnt[r]) : 0;
        end
    end
    // stalled supplies never come up; droop parks between the thresholds
    always_comb begin
        for (int r = 0; r < N_RAILS; r++) begin
            if (stall_in[r] || cnt[r] < RAMP) begin
                volt_out[r] = 12'h000;
            end else if (droop_in[r]) begin
                volt_out[r] = 12'h500;
            end else begin
                volt_out[r] = 12'h800;
            end
        end
    end
endmodule : mrps_supply_model
`default_nettype wire

// ### sim/multi_rail_power_sequencer_tb.sv
// self-checking bench of the multi-rail sequencer
`timescale 1ns/100ps
`default_nettype none
module multi_rail_power_sequencer_tb;
    import mrps_pkg::*;
    typedef struct {
        logic am;
        logic pm;
        logic op;
        logic pin;
        logic [7:0] general_input_pin;
        mrps_rvec_t mask;
        mrps_rvec_t exp;
    } mrps_row_t;
    logic sys_clk_in;
    logic rstn_in;
    logic auto_m, pin_m, op_on, op_off, ctl_pin, casc;
    logic [7:0] general_input_pin;
    mrps_rvec_t on_op, on_pin, on_par, on_gpi, on_lvl, mon_on, off_op, off_pin, off_gpi;
    mrps_rvec_t off_lvl, mon_off, off_imm, f_clr, rfault, stall, droop, en, pg, tmf, flt;
    mrps_rmask_t par_mask, fol_mask;
    mrps_rsel_t on_sel, off_sel;
    mrps_rdly_t ton_d, toff_d, ton_mx;
    mrps_rvolt_t volt, thr_on, thr_off;
    mrps_row_t rows [6];
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    // =========================================================
    // design and supplies, ms tick shortened to 8 cycles
    mrps_top #(.CLK_PER_MS(8)) dut (
        .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .auto_start_in(auto_m),
        .pin_mode_in(pin_m), .op_on_cmd_in(op_on), .op_off_cmd_in(op_off),
        .sequence_control_pin_in(ctl_pin), .general_input_pin_in(general_input_pin),
        .on_by_op_in(on_op), .on_by_pin_in(on_pin), .on_by_parent_in(on_par),
        .on_by_gpi_in(on_gpi), .on_parent_mask_in(par_mask), .on_gpi_sel_in(on_sel),
        .on_gpi_level_in(on_lvl), .on_monitor_only_in(mon_on), .off_by_op_in(off_op),
        .off_by_pin_in(off_pin), .off_by_gpi_in(off_gpi), .off_gpi_sel_in(off_sel),
        .off_gpi_level_in(off_lvl), .off_monitor_only_in(mon_off),
        .off_immediate_in(off_imm), .fault_follow_mask_in(fol_mask),
        .ton_delay_in(ton_d), .toff_delay_in(toff_d), .ton_max_in(ton_mx),
        .rail_volt_in(volt), .pg_on_thr_in(thr_on), .pg_off_thr_in(thr_off),
        .rail_fault_in(rfault), .fault_clear_in(f_clr), .rail_enable_out(en),
        .rail_pgood_out(pg), .ton_max_fault_out(tmf), .rail_faulted_out(flt),
        .cascade_shutdown_out(casc)
    );
    mrps_supply_model #(.RAMP(4)) supply (
        .clk_in(sys_clk_in), .en_in(en), .stall_in(stall), .droop_in(droop), .volt_out(volt)
    );
    // =========================================================
    // clock and hang guard
    initial begin
        sys_clk_in = 1'b0;
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end
    // the whole run needs about 2200 cycles
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_total++;
            $display("wrong value at %0t: run hung", $time);
            print_verdict();
        end
    end
    // =========================================================
    // tasks
    task automatic chk_vec(input mrps_rvec_t got, input mrps_rvec_t exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %0s got %03h want %03h", $time, what, got, exp);
        end
    endtask : chk_vec
    task automatic chk_bit(input logic got, input logic exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %0s got %b", $time, what, got);
        end
    endtask : chk_bit
    // mode is a level, so it is settled before reset lets go
    task automatic reset_run(input logic am, input logic pm);
        rstn_in = 1'b0;
        auto_m = am;
        pin_m = pm;
        ctl_pin = 1'b0;
        general_input_pin = 8'h00;
        stall = '0;
        droop = '0;
        repeat (8) @(negedge sys_clk_in);
        rstn_in = 1'b1;
        @(negedge sys_clk_in);
    endtask : reset_run
    task automatic pulse_op;
        op_on = 1'b1;
        @(negedge sys_clk_in);
        op_on = 1'b0;
    endtask : pulse_op
    task automatic wait_n(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask : wait_n
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict
    // =========================================================
    // stimulus
    initial begin
        {op_on, op_off, rfault, f_clr} = '0;
        on_op = 12'h015;
        on_pin = 12'h002;
        on_par = 12'h008;
        on_gpi = 12'h030;
        on_lvl = 12'h030;
        mon_on = 12'h004;
        {off_gpi, off_lvl, mon_off, off_sel, par_mask, fol_mask, on_sel} = '0;
        off_op = 12'hFFD; // rail 1 runs on the pin alone; a low op latch would block it
        off_pin = 12'h002;
        off_imm = 12'h008;
        par_mask[3][0] = 1'b1;
        fol_mask[3][0] = 1'b1;
        on_sel[4] = 3'h3;
        on_sel[5] = 3'h2;
        for (int r = 0; r < N_RAILS; r++) begin
            ton_d[r] = 12'h002;
            toff_d[r] = 12'h002;
            ton_mx[r] = 12'h000;
            thr_on[r] = 12'h700;
            thr_off[r] = 12'h400;
        end
        ton_mx[0] = 12'h003;
        rows[0] = '{1'b0, 1'b0, 1'b1, 1'b0, 8'h00, 12'hFFF, 12'h009};
        rows[1] = '{1'b0, 1'b0, 1'b0, 1'b1, 8'h00, 12'hFFF, 12'h002};
        rows[2] = '{1'b0, 1'b0, 1'b1, 1'b0, 8'h0C, 12'hFFF, 12'h039};
        rows[3] = '{1'b0, 1'b1, 1'b0, 1'b1, 8'h00, 12'hFFF, 12'h00B};
        rows[4] = '{1'b1, 1'b0, 1'b1, 1'b1, 8'h00, 12'hFC4, 12'hFC0};
        rows[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 8'h00, 12'hFFF, 12'h000};
        for (int i = 0; i < 6; i++) begin
            reset_run(rows[i].am, rows[i].pm);
            chk_vec(en, 12'h000, "enables after reset");
            ctl_pin = rows[i].pin;
            general_input_pin = rows[i].general_input_pin;
            if (rows[i].op) pulse_op();
            wait_n(200);
            chk_vec(en & rows[i].mask, rows[i].exp, "row enables");
            chk_vec(pg & rows[i].mask, rows[i].exp, "row power good");
            $display("row %0d done", i);
        end
        // soft stop: rail 3 drops at once, rail 0 waits out its off delay
        reset_run(1'b0, 1'b0);
        pulse_op();
        wait_n(200);
        op_off = 1'b1;
        @(negedge sys_clk_in);
        op_off = 1'b0;
        wait_n(5);
        chk_vec(en, 12'h001, "soft stop early");
        wait_n(30);
        chk_vec(en, 12'h000, "soft stop late");
        $display("soft stop done");
        // leader fault takes its follower down and is sticky until cleared
        reset_run(1'b0, 1'b0);
        pulse_op();
        wait_n(200);
        rfault = 12'h001;
        @(negedge sys_clk_in);
        rfault = '0;
        wait_n(40);
        chk_vec(en, 12'h000, "fault shutdown");
        chk_vec(flt & 12'h001, 12'h001, "fault flag");
        chk_bit(casc, 1'b1, "cascade");
        f_clr = 12'h001;
        @(negedge sys_clk_in);
        f_clr = '0;
        wait_n(3);
        chk_vec(flt & 12'h001, 12'h000, "fault cleared");
        $display("fault done");
        // stuck supplies: rail 0 has a 3 ms limit, rail 1 none
        reset_run(1'b0, 1'b0);
        stall = 12'h003;
        ctl_pin = 1'b1;
        pulse_op();
        wait_n(10);
        chk_vec(tmf, 12'h000, "limit too early");
        wait_n(200);
        chk_vec(tmf, 12'h001, "limit fault");
        chk_vec(en & 12'h003, 12'h002, "limit enables");
        $display("turn-on limit done");
        // code inside the band keeps regulation, below it drops it
        reset_run(1'b0, 1'b0);
        pulse_op();
        wait_n(200);
        droop = 12'h001;
        wait_n(10);
        chk_vec(pg & 12'h001, 12'h001, "held in band");
        stall = 12'h001;
        wait_n(3);
        chk_vec(pg & 12'h001, 12'h000, "dropped out");
        $display("hysteresis done");
        print_verdict();
    end
endmodule : multi_rail_power_sequencer_tb
`default_nettype wire
